//--- rpsf_regs.v
// paged status and frequency registers for two receive ports
// Operation
// - set unstable flag; held until read
// - line length change flag, clear on read
// - encoder error flag, clear on read
// - encoder errors need counting, threshold above one
// - buffer overflow flag, clear on read
// - video receive error summary, read only
// - cable fault when link expected, no clock
// - line count change flag, clear on read
// - frequency integer megahertz at 0x4F
// - frequency fraction 1/256 MHz at 0x50
// - one copy per port, paged by 0x4C
// - read port bit selects read copy
// - per port write enables, any combination
`timescale 1ns/1ps
`include "rpsf_map.vh"
module rpsf_regs #(
    parameter STABLE_COUNT = 4
) (
    input wire REF_CLK_I,
    input wire RST_N_I,
    input wire REG_WR_I,
    input wire REG_RD_I,
    input wire [7:0] REG_ADDR_I,
    input wire [7:0] REG_WDATA_I,
    output reg [7:0] REG_RDATA_O,
    output reg [1:0] PORT_WR_EN_O,
    input wire [1:0] LINE_LENGTH_INSTABILITY_FLAG_I,
    input wire [1:0] LINE_LENGTH_CHANGED_FLAG_I,
    input wire [1:0] ENC_ERR_I,
    input wire [1:0] ERR_COUNT_EN_I,
    input wire [15:0] LINK_ERR_THRESHOLD_I,
    input wire [1:0] BUF_OVERFLOW_I,
    input wire [1:0] VIDEO_RX_ERR_I,
    input wire [1:0] LINK_EXPECTED_I,
    input wire [1:0] LINK_CLK_SEEN_I,
    input wire [1:0] LINE_COUNT_CHANGED_FLAG_I,
    input wire [1:0] MEAS_VALID_I,
    input wire [15:0] MEAS_INT_I,
    input wire [15:0] MEAS_FRAC_I
);
    reg [7:0] sel_q;
    reg [1:0] vid_s1_q;
    reg [1:0] vid_s2_q;
    reg [1:0] exp_s1_q;
    reg [1:0] exp_s2_q;
    reg [1:0] clk_s1_q;
    reg [1:0] clk_s2_q;
    reg [7:0] rdata_d;
    wire [15:0] sts;
    wire [15:0] fint;
    wire [15:0] ffrac;
    wire rd_port;
    wire sts_read;
    wire [1:0] clr;
    assign rd_port = sel_q[`RPSF_SEL_READ_BIT];
    assign sts_read = REG_RD_I & (REG_ADDR_I == `RPSF_ADDR_STS2);
    // clear only the port whose copy was read
    assign clr = {sts_read & rd_port, sts_read & ~rd_port};
    // pin-level status passes two flops before use
    always @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            vid_s1_q <= 2'h0;
            vid_s2_q <= 2'h0;
            exp_s1_q <= 2'h0;
            exp_s2_q <= 2'h0;
            clk_s1_q <= 2'h0;
            clk_s2_q <= 2'h0;
        end else begin
            vid_s1_q <= VIDEO_RX_ERR_I;
            vid_s2_q <= vid_s1_q;
            exp_s1_q <= LINK_EXPECTED_I;
            exp_s2_q <= exp_s1_q;
            clk_s1_q <= LINK_CLK_SEEN_I;
            clk_s2_q <= clk_s1_q;
        end
    end
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_port
            rpsf_port #(.STABLE_COUNT(STABLE_COUNT)) u_port (
                .clk_i(REF_CLK_I),
                .rst_n_i(RST_N_I),
                .line_length_instability_flag_i(LINE_LENGTH_INSTABILITY_FLAG_I[p]),
                .line_length_changed_flag_i(LINE_LENGTH_CHANGED_FLAG_I[p]),
                .enc_err_i(ENC_ERR_I[p]),
                .err_count_en_i(ERR_COUNT_EN_I[p]),
                .link_err_threshold_i(LINK_ERR_THRESHOLD_I[p*8 +: 8]),
                .buf_overflow_i(BUF_OVERFLOW_I[p]),
                .video_rx_err_i(vid_s2_q[p]),
                .link_expected_i(exp_s2_q[p]),
                .link_clk_seen_i(clk_s2_q[p]),
                .line_count_changed_flag_i(LINE_COUNT_CHANGED_FLAG_I[p]),
                .meas_valid_i(MEAS_VALID_I[p]),
                .meas_int_i(MEAS_INT_I[p*8 +: 8]),
                .meas_frac_i(MEAS_FRAC_I[p*8 +: 8]),
                .clr_i(clr[p]),
                .sts_o(sts[p*8 +: 8]),
                .freq_int_o(fint[p*8 +: 8]),
                .freq_frac_o(ffrac[p*8 +: 8])
            );
        end
    endgenerate
    always @* begin
        rdata_d = `RPSF_RESET_BYTE;
        case (REG_ADDR_I)
            `RPSF_ADDR_PORT_SEL: rdata_d = sel_q;
            `RPSF_ADDR_STS2: rdata_d = rd_port ? sts[15:8] : sts[7:0];
            `RPSF_ADDR_FREQ_INT: rdata_d = rd_port ? fint[15:8] : fint[7:0];
            `RPSF_ADDR_FREQ_FRAC: rdata_d = rd_port ? ffrac[15:8] : ffrac[7:0];
            default: rdata_d = `RPSF_RESET_BYTE;
        endcase
    end
    // read data is captured in the same edge that clears the flags
    always @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            REG_RDATA_O <= `RPSF_RESET_BYTE;
            sel_q <= `RPSF_RESET_BYTE;
            PORT_WR_EN_O <= 2'h0;
        end else begin
            if (REG_RD_I) begin
                REG_RDATA_O <= rdata_d;
            end
            if (REG_WR_I && REG_ADDR_I == `RPSF_ADDR_PORT_SEL) begin
                sel_q <= REG_WDATA_I & `RPSF_SEL_MASK;
                PORT_WR_EN_O <= {REG_WDATA_I[`RPSF_SEL_WR1_BIT],
                    REG_WDATA_I[`RPSF_SEL_WR0_BIT]};
            end
        end
    end
endmodule

//--- rpsf_map.vh
// register map and field constants for the rx port status and frequency block
`ifndef RPSF_MAP_VH
`define RPSF_MAP_VH
`define RPSF_ADDR_PORT_SEL 8'h4C
`define RPSF_ADDR_STS2 8'h4E
`define RPSF_ADDR_FREQ_INT 8'h4F
`define RPSF_ADDR_FREQ_FRAC 8'h50
`define RPSF_SEL_READ_BIT 4
`define RPSF_SEL_WR1_BIT 1
`define RPSF_SEL_WR0_BIT 0
`define RPSF_SEL_MASK 8'h13
`define RPSF_BIT_LEN_UNSTABLE 7
`define RPSF_BIT_LEN_CHG 6
`define RPSF_BIT_ENC_ERR 5
`define RPSF_BIT_BUF_ERR 4
`define RPSF_BIT_VIDEO_ERR 3
`define RPSF_BIT_FREQUENCY_SETTLED_FLAG 2
`define RPSF_BIT_CABLE_FAULT 1
`define RPSF_BIT_CNT_CHG 0
`define RPSF_RESET_BYTE 8'h00
`define RPSF_MIN_ERR_THRESHOLD 8'h01
`endif

//--- rpsf_port.v
// one receive port copy of the status flags and frequency readings
`timescale 1ns/1ps
`include "rpsf_map.vh"
module rpsf_port #(
    parameter STABLE_COUNT = 4
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire line_length_instability_flag_i,
    input wire line_length_changed_flag_i,
    input wire enc_err_i,
    input wire err_count_en_i,
    input wire [7:0] link_err_threshold_i,
    input wire buf_overflow_i,
    input wire video_rx_err_i,
    input wire link_expected_i,
    input wire link_clk_seen_i,
    input wire line_count_changed_flag_i,
    input wire meas_valid_i,
    input wire [7:0] meas_int_i,
    input wire [7:0] meas_frac_i,
    input wire clr_i,
    output wire [7:0] sts_o,
    output wire [7:0] freq_int_o,
    output wire [7:0] freq_frac_o
);
    reg len_unstable_q;
    reg len_chg_q;
    reg enc_err_q;
    reg buf_err_q;
    reg cnt_chg_q;
    reg stable_q;
    reg [7:0] int_q;
    reg [7:0] frac_q;
    reg [3:0] agree_q;
    wire enc_ok;
    wire same;
    assign enc_ok = enc_err_i & err_count_en_i
        & (link_err_threshold_i > `RPSF_MIN_ERR_THRESHOLD);
    assign same = (meas_int_i == int_q) & (meas_frac_i == frac_q);
    // set wins over the clearing read, so no event is lost
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            len_unstable_q <= 1'b0;
            len_chg_q <= 1'b0;
            enc_err_q <= 1'b0;
            buf_err_q <= 1'b0;
            cnt_chg_q <= 1'b0;
        end else begin
            len_unstable_q <= line_length_instability_flag_i | (len_unstable_q & ~clr_i);
            len_chg_q <= line_length_changed_flag_i | (len_chg_q & ~clr_i);
            enc_err_q <= enc_ok | (enc_err_q & ~clr_i);
            buf_err_q <= buf_overflow_i | (buf_err_q & ~clr_i);
            cnt_chg_q <= line_count_changed_flag_i | (cnt_chg_q & ~clr_i);
        end
    end
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_q <= `RPSF_RESET_BYTE;
            frac_q <= `RPSF_RESET_BYTE;
            agree_q <= 4'h0;
            stable_q <= 1'b0;
        end else if (meas_valid_i) begin
            int_q <= meas_int_i;
            frac_q <= meas_frac_i;
            if (!same) begin
                agree_q <= 4'h0;
                stable_q <= 1'b0;
            end else if (agree_q >= STABLE_COUNT[3:0] - 4'h1) begin
                stable_q <= 1'b1;
            end else begin
                agree_q <= agree_q + 4'h1;
            end
        end
    end
    assign sts_o = {len_unstable_q, len_chg_q, enc_err_q, buf_err_q, video_rx_err_i,
        stable_q, link_expected_i & ~link_clk_seen_i, cnt_chg_q};
    assign freq_int_o = int_q;
    assign freq_frac_o = frac_q;
endmodule

//--- rpsf_regs_monitor.sv
// checker for the paged rx status registers
`timescale 1ns/1ps
module rpsf_regs_monitor (
    input wire REF_CLK_I,
    input wire RST_N_I,
    input wire REG_WR_I,
    input wire REG_RD_I,
    input wire [7:0] REG_ADDR_I,
    input wire [7:0] REG_WDATA_I,
    input wire [7:0] REG_RDATA_O,
    input wire [1:0] PORT_WR_EN_O,
    input wire [1:0] LINE_LENGTH_INSTABILITY_FLAG_I,
    input wire [1:0] LINE_LENGTH_CHANGED_FLAG_I,
    input wire [1:0] BUF_OVERFLOW_I
);
    reg sel_q;
    wire ws = REG_WR_I && REG_ADDR_I == 8'h4C;
    wire rs = REG_RD_I && !REG_WR_I && REG_ADDR_I == 8'h4E;
    wire hole = REG_ADDR_I < 8'h4C || REG_ADDR_I == 8'h4D || REG_ADDR_I > 8'h50;
    // mirror of the read page, so flags are matched to the shown port
    always @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) sel_q <= 1'b0;
        else if (ws) sel_q <= REG_WDATA_I[4];
    end
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    a_wren_load: assert property (ws |=> PORT_WR_EN_O == $past(REG_WDATA_I[1:0]))
        else $error("wren load");
    a_wren_hold: assert property (!ws |=> $stable(PORT_WR_EN_O))
        else $error("wren hold");
    a_rdata_hold: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
        else $error("rdata hold");
    a_hole_zero: assert property (REG_RD_I && hole |=> REG_RDATA_O == 8'h00)
        else $error("hole");
    a_sel_read: assert property (REG_RD_I && !REG_WR_I && REG_ADDR_I == 8'h4C
        |=> REG_RDATA_O == {3'h0, sel_q, 2'h0, PORT_WR_EN_O}) else $error("sel");
    a_unstable_set: assert property (LINE_LENGTH_INSTABILITY_FLAG_I[sel_q] && !REG_WR_I ##1 rs
        |=> REG_RDATA_O[7]) else $error("unstable");
    a_len_clear: assert property (rs && !LINE_LENGTH_CHANGED_FLAG_I[sel_q] ##1 rs
        |=> !REG_RDATA_O[6]) else $error("len clear");
    a_event_wins: assert property (rs && BUF_OVERFLOW_I[sel_q] ##1 rs
        |=> REG_RDATA_O[4]) else $error("event wins");
    cover property (rs ##1 rs);
    cover property (ws);
    cover property (LINE_LENGTH_INSTABILITY_FLAG_I[sel_q] ##1 rs);
endmodule
bind rpsf_regs rpsf_regs_monitor u_mon (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I),
    .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .PORT_WR_EN_O(PORT_WR_EN_O),
    .LINE_LENGTH_INSTABILITY_FLAG_I(LINE_LENGTH_INSTABILITY_FLAG_I), .LINE_LENGTH_CHANGED_FLAG_I(LINE_LENGTH_CHANGED_FLAG_I),
    .BUF_OVERFLOW_I(BUF_OVERFLOW_I));

//--- rpsf_link_model.sv
// far-side model: link event pulses and frequency measurements
`timescale 1ns/1ps
module rpsf_link_model (
    input wire clk_i,
    output reg [9:0] ev_o = 10'h000,
    output reg [1:0] vld_o = 2'h0,
    output reg [15:0] int_o = 16'h0000,
    output reg [15:0] frac_o = 16'h0000
);
    task pulse(input integer k, input integer p);
        ev_o[2 * k + p] = 1'b1;
        @(posedge clk_i);
        #1;
        ev_o = 10'h000;
    endtask
    // released bytes invert so stale data cannot pass for fresh
    // valid stays up over n edges, so a run of measurements never re-strobes
    task meas(input integer p, input integer n, input [7:0] i, input [7:0] f);
        vld_o[p] = 1'b1;
        int_o[8 * p +: 8] = i;
        frac_o[8 * p +: 8] = f;
        repeat (n) @(posedge clk_i);
        #1;
        vld_o = 2'h0;
        int_o = ~int_o;
        frac_o = ~frac_o;
    endtask
endmodule

//--- tb_rpsf_regs.sv
// self-checking bench for the paged rx status registers
`timescale 1ns/1ps
module tb_rpsf_regs;
    reg clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    reg [1:0] vid = 2'h0, lexp = 2'h0, seen = 2'h3, en = 2'h3;
    reg [7:0] addr = 8'h00, wdata = 8'h00, fv = 8'h00;
    reg [15:0] thr = 16'h0202;
    wire [7:0] rdata;
    wire [1:0] wren, mv;
    wire [9:0] ev;
    wire [15:0] mi, mf;
    integer error_cnt = 0, checks = 0, cyc = 0, p, k;
    always #5 clk = ~clk;
    rpsf_link_model lm (.clk_i(clk), .ev_o(ev), .vld_o(mv), .int_o(mi), .frac_o(mf));
    rpsf_regs DUT (.REF_CLK_I(clk), .RST_N_I(rst_n), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .PORT_WR_EN_O(wren),
        .LINE_LENGTH_INSTABILITY_FLAG_I(ev[1:0]), .LINE_LENGTH_CHANGED_FLAG_I(ev[3:2]), .ENC_ERR_I(ev[5:4]),
        .ERR_COUNT_EN_I(en), .LINK_ERR_THRESHOLD_I(thr), .BUF_OVERFLOW_I(ev[7:6]),
        .VIDEO_RX_ERR_I(vid), .LINK_EXPECTED_I(lexp), .LINK_CLK_SEEN_I(seen),
        .LINE_COUNT_CHANGED_FLAG_I(ev[9:8]), .MEAS_VALID_I(mv), .MEAS_INT_I(mi), .MEAS_FRAC_I(mf));
    task cmp(input [7:0] got, input [7:0] e);
        checks = checks + 1;
        if (got !== e) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask
    // strobes stay up between calls so reads run back to back
    task acc(input w, input [7:0] a, input [7:0] d, input [7:0] e);
        wr = w;
        rd = !w;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1;
        if (!w) cmp(rdata, e);
    endtask
    task far(input integer k, input integer p);
        wr = 1'b0;
        rd = 1'b0;
        if (k < 5) lm.pulse(k, p);
        else if (k < 10) lm.meas(p, k - 4, fv, 8'h80);
        else begin
            @(posedge clk);
            #1;
        end
    endtask
    task conclude;
        $display("checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            error_cnt = error_cnt + 1;
            conclude;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        for (k = 0; k < 5; k = k + 1) acc(0, 8'(8'h4C + k), 8'h00, 8'h00);
        for (p = 0; p < 2; p = p + 1) begin
            acc(1, 8'h4C, p ? 8'h12 : 8'h01, 8'h00);
            acc(0, 8'h4C, 8'h00, p ? 8'h12 : 8'h01);
            cmp({6'h00, wren}, 8'h01 << p);
            for (k = 0; k < 5; k = k + 1) begin
                far(k, p);
                acc(0, 8'h4E, 8'h00, k == 4 ? 8'h01 : 8'h80 >> k);
                acc(0, 8'h4E, 8'h00, 8'h00);
            end
            thr = 16'h0101;
            far(2, p);
            acc(0, 8'h4E, 8'h00, 8'h00);
            thr = 16'h0202;
            en = 2'h0;
            far(2, p);
            acc(0, 8'h4E, 8'h00, 8'h00);
            en = 2'h3;
            fork
                lm.pulse(3, p);
                acc(0, 8'h4E, 8'h00, 8'h00);
            join
            acc(0, 8'h4E, 8'h00, 8'h10);
            vid = 2'h1 << p;
            lexp = 2'h3;
            seen = ~(2'h1 << p);
            repeat (3) far(10, p);
            acc(0, 8'h4E, 8'h00, 8'h0A);
            vid = 2'h0;
            seen = 2'h3;
            repeat (3) far(10, p);
            acc(0, 8'h4E, 8'h00, 8'h00);
            fv = 8'(8'h20 + p);
            // one update plus four agreeing measurements before stable
            far(9, p);
            acc(0, 8'h4E, 8'h00, 8'h04);
            acc(0, 8'h4F, 8'h00, fv);
            acc(0, 8'h50, 8'h00, 8'h80);
            fv = 8'(8'h40 + p);
            far(5, p);
            acc(0, 8'h4E, 8'h00, 8'h00);
        end
        acc(1, 8'h4C, 8'h03, 8'h00);
        cmp({6'h00, wren}, 8'h03);
        acc(0, 8'h4F, 8'h00, 8'h40);
        conclude;
    end
endmodule
